// ---- include/pio_cfg.svh ----
// register offsets, field positions, reset values for the parallel io unit
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
`define PIO_OFF_PORT_A 8'h00
`define PIO_OFF_PORT_B 8'h04
`define PIO_OFF_PORT_C 8'h08
`define PIO_OFF_MODE_CTRL 8'h0c
`define PIO_CTRL_SEL_BIT 7
`define PIO_CTRL_LOWER_DIR 0
`define PIO_CTRL_B_DIR 1
`define PIO_CTRL_B_MODE 2
`define PIO_CTRL_UPPER_DIR 3
`define PIO_CTRL_A_DIR 4
`define PIO_CTRL_A_MODE_LO 5
`define PIO_CTRL_A_MODE_HI 6
`define PIO_CTRL_SR_BIT 0
`define PIO_CTRL_BSEL_LO 1
`define PIO_CTRL_BSEL_HI 3
`define PIO_CTRL_RESET 8'h9b
`define PIO_PC_B_IRQ 0
`define PIO_PC_B_FULL 1
`define PIO_PC_B_HS 2
`define PIO_PC_A_IRQ 3
`define PIO_PC_A_STB 4
`define PIO_PC_A_IBF 5
`define PIO_PC_A_ACK 6
`define PIO_PC_A_OBF 7
`endif

// ---- include/pio_pkg.sv ----
// types shared by the parallel io unit
package pio_pkg;
   typedef enum logic [2:0] {
      PIO_BASIC = 3'b001,
      PIO_STROBED = 3'b010,
      PIO_BIDIR = 3'b100
   } pio_mode_t;
endpackage

// ---- design/pio_hs_chan.sv ----
// one strobed handshake channel: input latch, output-full, irq request
`timescale 1ns/1ps
module pio_hs_chan #(
   parameter int WIDTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_clear,
   input wire logic i_in_en,
   input wire logic i_out_en,
   input wire logic i_strobe_n,
   input wire logic i_accept_n,
   input wire logic [WIDTH-1:0] i_pins,
   input wire logic i_cpu_read,
   input wire logic i_cpu_write,
   input wire logic i_in_irq_en,
   input wire logic i_out_irq_en,
   output logic [WIDTH-1:0] o_in_data,
   output logic o_input_full,
   output logic o_output_full_n,
   output logic o_irq_request
);
   logic [WIDTH-1:0] in_q, in_d;
   logic ibf_q, ibf_d, obf_q, obf_d, irq_in_q, irq_in_d, irq_out_q, irq_out_d;
   logic stb_prev_q, stb_prev_d;

   always_comb begin
      in_d = in_q;
      ibf_d = ibf_q;
      obf_d = obf_q;
      irq_in_d = irq_in_q;
      irq_out_d = irq_out_q;
      // remembers that a write-accept cycle has happened since the last clear
      stb_prev_d = i_clear ? 1'b0 : (stb_prev_q | (obf_q & ~i_accept_n));
      // the input latch follows a low strobe even across a clear, so no pin sample is lost
      if (i_in_en && !i_strobe_n) begin
         in_d = i_pins; // R10
      end
      if (i_clear) begin
         ibf_d = 1'b0;
         obf_d = 1'b0;
         irq_in_d = 1'b0;
         irq_out_d = 1'b0;
      end else begin
         if (i_in_en) begin
            if (!i_strobe_n) begin
               ibf_d = 1'b1; // R12
            end else if (i_cpu_read) begin
               ibf_d = 1'b0; // R12
            end
            // strobe high after a fill raises the request; a read in the same cycle wins
            // because it empties the latch, and a set then would leave a stale request
            if (i_strobe_n && ibf_q && i_in_irq_en && !i_cpu_read) begin
               irq_in_d = 1'b1; // R13
            end else if (i_cpu_read || !i_in_irq_en) begin
               irq_in_d = 1'b0; // R13
            end
         end else begin
            ibf_d = 1'b0;
            irq_in_d = 1'b0;
         end
         if (i_out_en) begin
            if (i_cpu_write) begin
               obf_d = 1'b1; // R15
            end else if (!i_accept_n) begin
               obf_d = 1'b0; // R14
            end
            if (i_cpu_write || !i_out_irq_en) begin
               irq_out_d = 1'b0; // R16
            end else if (i_accept_n && !obf_q && i_out_irq_en && stb_prev_q) begin
               irq_out_d = 1'b1; // R16
            end
         end else begin
            obf_d = 1'b0;
            irq_out_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         in_q <= '0;
         ibf_q <= 1'b0;
         obf_q <= 1'b0;
         irq_in_q <= 1'b0;
         irq_out_q <= 1'b0;
         stb_prev_q <= 1'b0;
      end else begin
         in_q <= in_d;
         ibf_q <= ibf_d;
         obf_q <= obf_d;
         irq_in_q <= irq_in_d;
         irq_out_q <= irq_out_d;
         stb_prev_q <= stb_prev_d;
      end
   end

   assign o_in_data = in_q;
   assign o_input_full = ibf_q;
   assign o_output_full_n = ~obf_q;
   assign o_irq_request = irq_in_q | irq_out_q;

   property p_ibf_on_strobe;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_in_en && !i_clear && !i_strobe_n) |=> o_input_full;
   endproperty
   a_ibf_on_strobe: assert property (p_ibf_on_strobe) // R12
      else $error("input full not set by strobe");

   property p_obf_on_write;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_out_en && !i_clear && i_cpu_write) |=> !o_output_full_n;
   endproperty
   a_obf_on_write: assert property (p_obf_on_write) // R15
      else $error("output full not set by write");

   property p_obf_clear_on_accept;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_out_en && !i_cpu_write && !i_accept_n) |=> o_output_full_n;
   endproperty
   a_obf_clear_on_accept: assert property (p_obf_clear_on_accept) // R14
      else $error("output full not cleared by accept");

   property p_irq_cleared_by_write;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_cpu_write && !i_in_en) |=> !o_irq_request;
   endproperty
   a_irq_cleared_by_write: assert property (p_irq_cleared_by_write) // R16
      else $error("output irq survived a data write");

   property p_irq_cleared_by_read;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_cpu_read && !i_out_en) |=> !o_irq_request;
   endproperty
   a_irq_cleared_by_read: assert property (p_irq_cleared_by_read) // R13
      else $error("input irq survived a data read");

   property p_in_latch;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_in_en && !i_strobe_n) |=> (o_in_data == $past(i_pins));
   endproperty
   a_in_latch: assert property (p_in_latch) // R10
      else $error("input latch missed pin data");
endmodule // pio_hs_chan

// ---- design/pio_port.sv ----
// parallel io unit: three 8-bit ports, mode control word, strobed handshakes
//
// Behaviour
// R01: bit 7 picks mode write or bit set/reset
// R02: bits 2:0 set group b directions, mode
// R03: bits 6:3 set group a directions, mode
// R04: bits 3:1 pick pc bit, bit 0 value
// R05: handshake-pin set/reset writes interrupt enables instead
// R06: mode change or reset clears interrupt enables
// R07: basic-mode group raises no interrupt request
// R08: basic mode latches outputs, inputs flow through
// R09: strobed mode gives pc handshakes, latched data
// R10: low strobe loads input latch, rise captures
// R11: peripheral holds data until strobe returns high
// R12: input full rises on strobe, falls on read
// R13: input irq on strobe high, full, enable
// R14: low accept clears output full
// R15: output full low on write until accept
// R16: output irq on accept high, empty, enable
// R17: bidirectional port a with five handshake lines
// R18: control write clears latches, status, enables
// R19: reset control word: all inputs, basic mode
// R20: newly output ports start driving low
// R21: control word is write-only, reads zero
// R22: handshake pins take their needed direction
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "pio_cfg.svh"
module pio_port (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_pa,
   output logic [7:0] o_pa,
   output logic [7:0] o_pa_oe,
   input wire logic [7:0] i_pb,
   output logic [7:0] o_pb,
   output logic [7:0] o_pb_oe,
   input wire logic [7:0] i_pc,
   output logic [7:0] o_pc,
   output logic [7:0] o_pc_oe,
   output pio_pkg::pio_mode_t o_group_a_mode,
   output pio_pkg::pio_mode_t o_group_b_mode
);
   import pio_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // every pin goes through two flops before use
   logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q, pc_s1_q, pc_s2_q;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pa_s1_q <= 8'hff;
         pa_s2_q <= 8'hff;
         pb_s1_q <= 8'hff;
         pb_s2_q <= 8'hff;
         pc_s1_q <= 8'hff;
         pc_s2_q <= 8'hff;
      end else begin
         pa_s1_q <= i_pa;
         pa_s2_q <= pa_s1_q;
         pb_s1_q <= i_pb;
         pb_s2_q <= pb_s1_q;
         pc_s1_q <= i_pc;
         pc_s2_q <= pc_s1_q;
      end
   end

   logic [7:0] ctrl_q, ctrl_d, pa_out_q, pa_out_d, pb_out_q, pb_out_d, pc_out_q, pc_out_d;
   logic inte_a_in_q, inte_a_in_d, inte_a_out_q, inte_a_out_d, inte_b_q, inte_b_d;
   logic [7:0] rdata_q, rdata_d;
   logic ctrl_wr, sr_wr, mode_wr;
   logic [2:0] bsel;
   pio_mode_t mode_a, mode_b;
   logic a_hs, b_hs, a_in_en, a_out_en, b_in_en, b_out_en;
   logic a_rd, a_wr, b_rd, b_wr;
   logic [7:0] a_in_data, b_in_data;
   logic a_ibf, a_obf_n, a_irq, b_ibf, b_obf_n, b_irq;

   assign ctrl_wr = i_wr && hit(i_addr, `PIO_OFF_MODE_CTRL);
   assign mode_wr = ctrl_wr && i_wdata[`PIO_CTRL_SEL_BIT]; // R01
   assign sr_wr = ctrl_wr && !i_wdata[`PIO_CTRL_SEL_BIT]; // R01
   assign bsel = i_wdata[`PIO_CTRL_BSEL_HI:`PIO_CTRL_BSEL_LO]; // R04

   always_comb begin
      if (ctrl_q[`PIO_CTRL_A_MODE_HI]) begin
         mode_a = PIO_BIDIR; // R03
      end else if (ctrl_q[`PIO_CTRL_A_MODE_LO]) begin
         mode_a = PIO_STROBED; // R03
      end else begin
         mode_a = PIO_BASIC;
      end
      mode_b = ctrl_q[`PIO_CTRL_B_MODE] ? PIO_STROBED : PIO_BASIC; // R02
   end

   assign a_hs = (mode_a != PIO_BASIC); // R09
   assign b_hs = (mode_b != PIO_BASIC); // R09
   assign a_in_en = (mode_a == PIO_BIDIR) || (a_hs && ctrl_q[`PIO_CTRL_A_DIR]); // R17
   assign a_out_en = (mode_a == PIO_BIDIR) || (a_hs && !ctrl_q[`PIO_CTRL_A_DIR]); // R17
   assign b_in_en = b_hs && ctrl_q[`PIO_CTRL_B_DIR];
   assign b_out_en = b_hs && !ctrl_q[`PIO_CTRL_B_DIR];
   assign a_rd = i_rd && hit(i_addr, `PIO_OFF_PORT_A);
   assign a_wr = i_wr && hit(i_addr, `PIO_OFF_PORT_A);
   assign b_rd = i_rd && hit(i_addr, `PIO_OFF_PORT_B);
   assign b_wr = i_wr && hit(i_addr, `PIO_OFF_PORT_B);

   // control word, output latches and interrupt enables
   always_comb begin
      ctrl_d = ctrl_q;
      pa_out_d = pa_out_q;
      pb_out_d = pb_out_q;
      pc_out_d = pc_out_q;
      inte_a_in_d = inte_a_in_q;
      inte_a_out_d = inte_a_out_q;
      inte_b_d = inte_b_q;
      if (mode_wr) begin
         ctrl_d = i_wdata;
         pa_out_d = 8'h00; // R18 R20
         pb_out_d = 8'h00; // R18 R20
         pc_out_d = 8'h00; // R18 R20
         inte_a_in_d = 1'b0; // R06 R18
         inte_a_out_d = 1'b0; // R06 R18
         inte_b_d = 1'b0; // R06 R18
      end else if (sr_wr) begin
         // handshake positions steer the enables, not the pin latch
         if (a_in_en && bsel == 3'd`PIO_PC_A_STB) begin
            inte_a_in_d = i_wdata[`PIO_CTRL_SR_BIT]; // R05
         end else if (a_out_en && bsel == 3'd`PIO_PC_A_ACK) begin
            inte_a_out_d = i_wdata[`PIO_CTRL_SR_BIT]; // R05
         end else if (b_hs && bsel == 3'd`PIO_PC_B_HS) begin
            inte_b_d = i_wdata[`PIO_CTRL_SR_BIT]; // R05
         end else begin
            pc_out_d[bsel] = i_wdata[`PIO_CTRL_SR_BIT]; // R04
         end
      end else begin
         if (a_wr) begin
            pa_out_d = i_wdata; // R08
         end
         if (b_wr) begin
            pb_out_d = i_wdata; // R08
         end
         if (i_wr && hit(i_addr, `PIO_OFF_PORT_C)) begin
            pc_out_d = i_wdata;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_q <= `PIO_CTRL_RESET; // R19
         pa_out_q <= 8'h00;
         pb_out_q <= 8'h00;
         pc_out_q <= 8'h00;
         inte_a_in_q <= 1'b0; // R06
         inte_a_out_q <= 1'b0; // R06
         inte_b_q <= 1'b0; // R06
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         pa_out_q <= pa_out_d;
         pb_out_q <= pb_out_d;
         pc_out_q <= pc_out_d;
         inte_a_in_q <= inte_a_in_d;
         inte_a_out_q <= inte_a_out_d;
         inte_b_q <= inte_b_d;
         rdata_q <= rdata_d;
      end
   end

   pio_hs_chan #(.WIDTH(8)) u_chan_a (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_clear(mode_wr), // R18
      .i_in_en(a_in_en),
      .i_out_en(a_out_en),
      .i_strobe_n(pc_s2_q[`PIO_PC_A_STB]), // R11
      .i_accept_n(pc_s2_q[`PIO_PC_A_ACK]),
      .i_pins(pa_s2_q),
      .i_cpu_read(a_rd),
      .i_cpu_write(a_wr),
      .i_in_irq_en(inte_a_in_q),
      .i_out_irq_en(inte_a_out_q),
      .o_in_data(a_in_data),
      .o_input_full(a_ibf),
      .o_output_full_n(a_obf_n),
      .o_irq_request(a_irq)
   );

   pio_hs_chan #(.WIDTH(8)) u_chan_b (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_clear(mode_wr), // R18
      .i_in_en(b_in_en),
      .i_out_en(b_out_en),
      .i_strobe_n(pc_s2_q[`PIO_PC_B_HS]),
      .i_accept_n(pc_s2_q[`PIO_PC_B_HS]),
      .i_pins(pb_s2_q),
      .i_cpu_read(b_rd),
      .i_cpu_write(b_wr),
      .i_in_irq_en(inte_b_q),
      .i_out_irq_en(inte_b_q),
      .o_in_data(b_in_data),
      .o_input_full(b_ibf),
      .o_output_full_n(b_obf_n),
      .o_irq_request(b_irq)
   );

   // port c pin view: handshake lines override the general-purpose latch
   logic [7:0] pc_drive, pc_oe, pc_view;
   always_comb begin
      pc_drive = pc_out_q;
      pc_oe = {{4{!ctrl_q[`PIO_CTRL_UPPER_DIR]}}, {4{!ctrl_q[`PIO_CTRL_LOWER_DIR]}}};
      pc_view = pc_s2_q;
      // basic-mode groups never reach the request pins
      if (a_hs) begin // R07
         pc_drive[`PIO_PC_A_IRQ] = a_irq; // R09
         pc_oe[`PIO_PC_A_IRQ] = 1'b1; // R22
         pc_view[`PIO_PC_A_IRQ] = a_irq;
      end
      if (a_in_en) begin
         pc_drive[`PIO_PC_A_IBF] = a_ibf;
         pc_oe[`PIO_PC_A_IBF] = 1'b1; // R22
         pc_oe[`PIO_PC_A_STB] = 1'b0; // R22
         pc_view[`PIO_PC_A_IBF] = a_ibf;
         pc_view[`PIO_PC_A_STB] = inte_a_in_q;
      end
      if (a_out_en) begin
         pc_drive[`PIO_PC_A_OBF] = a_obf_n;
         pc_oe[`PIO_PC_A_OBF] = 1'b1; // R22
         pc_oe[`PIO_PC_A_ACK] = 1'b0; // R22
         pc_view[`PIO_PC_A_OBF] = a_obf_n;
         pc_view[`PIO_PC_A_ACK] = inte_a_out_q;
      end
      if (b_hs) begin // R07
         pc_drive[`PIO_PC_B_IRQ] = b_irq;
         pc_drive[`PIO_PC_B_FULL] = b_in_en ? b_ibf : b_obf_n;
         pc_oe[`PIO_PC_B_IRQ] = 1'b1; // R22
         pc_oe[`PIO_PC_B_FULL] = 1'b1; // R22
         pc_oe[`PIO_PC_B_HS] = 1'b0; // R22
         pc_view[`PIO_PC_B_IRQ] = b_irq;
         pc_view[`PIO_PC_B_FULL] = pc_drive[`PIO_PC_B_FULL];
         pc_view[`PIO_PC_B_HS] = inte_b_q;
      end
   end

   assign o_pc = pc_drive;
   assign o_pc_oe = pc_oe;
   assign o_pb = pb_out_q;
   assign o_pb_oe = {8{!ctrl_q[`PIO_CTRL_B_DIR]}};
   assign o_pa = pa_out_q;
   // bidirectional port a drives only while the peripheral accepts
   assign o_pa_oe = (mode_a == PIO_BIDIR) ? {8{!pc_s2_q[`PIO_PC_A_ACK]}} : // R17
                    {8{!ctrl_q[`PIO_CTRL_A_DIR]}};
   assign o_group_a_mode = mode_a;
   assign o_group_b_mode = mode_b;

   // read mux; basic-mode inputs read the pins, strobed inputs the latch
   always_comb begin
      rdata_d = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `PIO_OFF_PORT_A: rdata_d = a_in_en ? a_in_data :
                                      (ctrl_q[`PIO_CTRL_A_DIR] ? pa_s2_q : pa_out_q); // R08
            `PIO_OFF_PORT_B: rdata_d = b_in_en ? b_in_data :
                                      (ctrl_q[`PIO_CTRL_B_DIR] ? pb_s2_q : pb_out_q); // R08
            `PIO_OFF_PORT_C: rdata_d = pc_view;
            default: rdata_d = 8'h00; // R21
         endcase
      end
   end
   assign o_rdata = rdata_q;

   property p_ctrl_hidden;
      @(posedge i_sys_clk) disable iff (i_reset)
         (i_rd && i_addr == `PIO_OFF_MODE_CTRL) |=> (o_rdata == 8'h00);
   endproperty
   a_ctrl_hidden: assert property (p_ctrl_hidden) // R21
      else $error("control word readable");

   property p_mode_clears;
      @(posedge i_sys_clk) disable iff (i_reset)
         mode_wr |=> (pa_out_q == 8'h00 && pb_out_q == 8'h00 && !inte_a_in_q && !inte_b_q);
   endproperty
   a_mode_clears: assert property (p_mode_clears) // R18
      else $error("mode write left state behind");

   property p_basic_no_irq;
      @(posedge i_sys_clk) disable iff (i_reset)
         (mode_b == PIO_BASIC && !ctrl_q[`PIO_CTRL_LOWER_DIR]) |-> (o_pc[0] == pc_out_q[0]);
   endproperty
   a_basic_no_irq: assert property (p_basic_no_irq) // R07
      else $error("basic group drove a request");

   property p_inte_set;
      @(posedge i_sys_clk) disable iff (i_reset)
         (sr_wr && b_hs && i_wdata[3:0] == 4'h5) |=> inte_b_q;
   endproperty
   a_inte_set: assert property (p_inte_set) // R05
      else $error("enable not set by bit write");
endmodule // pio_port

// ---- test/pio_periph.sv ----
// behavioural peripheral on the strobed handshake pins of the parallel io unit
`timescale 1ns/1ps
module pio_periph (
   input wire logic i_sys_clk,
   output logic [7:0] o_data,
   output logic o_strobe_n,
   output logic o_accept_n
);
   initial begin
      o_data = 8'h00;
      o_strobe_n = 1'b1;
      o_accept_n = 1'b1;
   end
   // strobed input transfer; dly lets the model answer promptly or slowly
   task automatic send(input logic [7:0] d, input int dly);
      repeat (dly) @(posedge i_sys_clk);
      @(posedge i_sys_clk);
      o_data <= d;
      @(posedge i_sys_clk);
      o_strobe_n <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      o_strobe_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      // released bus shows the inverse, so a stale value is never mistaken for data
      o_data <= ~d;
   endtask
   task automatic accept(input int dly);
      repeat (dly) @(posedge i_sys_clk);
      @(posedge i_sys_clk);
      o_accept_n <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      o_accept_n <= 1'b1;
   endtask
endmodule // pio_periph

// ---- test/pio_port_test.sv ----
// testbench for the parallel io unit with a peripheral model
`timescale 1ns/1ps
module pio_port_test;
   import pio_pkg::*;
   logic i_sys_clk, i_reset, i_wr, i_rd, stb_n, acc_n;
   logic [7:0] i_addr, i_wdata, o_rdata, o_pa, o_pa_oe, o_pb, o_pb_oe, o_pc, o_pc_oe;
   logic [7:0] pa_in, pb_in, pc_in, pd, exp;
   pio_mode_t o_group_a_mode, o_group_b_mode;
   int fail_count = 0;
   int compares = 0;
   int n;
   // control word, a mode, b mode, pa oe, pb oe, pc oe
   logic [47:0] rows [9] = '{48'h80_01_01_ff_ff_ff, 48'h9b_01_01_00_00_00,
      48'h89_01_01_ff_ff_00, 48'h92_01_01_00_00_ff, 48'ha0_02_01_ff_ff_bf,
      48'hb8_02_01_00_ff_2f, 48'hc0_04_01_00_ff_af, 48'he0_04_01_00_ff_af,
      48'h84_01_02_ff_ff_fb};
   pio_periph i_pio_periph (.i_sys_clk(i_sys_clk), .o_data(pd), .o_strobe_n(stb_n),
      .o_accept_n(acc_n));
   pio_port i_pio_port (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pa(pa_in),
      .o_pa(o_pa), .o_pa_oe(o_pa_oe), .i_pb(pb_in), .o_pb(o_pb), .o_pb_oe(o_pb_oe),
      .i_pc(pc_in), .o_pc(o_pc), .o_pc_oe(o_pc_oe), .o_group_a_mode(o_group_a_mode),
      .o_group_b_mode(o_group_b_mode));
   // undriven pins see the peripheral; spare pc inputs rest on pull-ups
   assign pa_in = (o_pa & o_pa_oe) | (pd & ~o_pa_oe);
   assign pb_in = (o_pb & o_pb_oe) | (pd & ~o_pb_oe);
   assign pc_in = (o_pc & o_pc_oe) |
      ({1'b1, acc_n, 1'b1, stb_n, 1'b1, stb_n & acc_n, 2'b11} & ~o_pc_oe);
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   task automatic print_verdict;
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, want);
   endtask
   task automatic wait_pc(input int b, input logic v);
      int k;
      for (k = 0; k < 40 && o_pc[b] !== v; k++) @(posedge i_sys_clk);
      chk({7'h00, o_pc[b]}, {7'h00, v});
      if (k == 40) print_verdict();
   endtask
   initial begin
      repeat (100000) @(posedge i_sys_clk);
      fail_count++;
      print_verdict();
   end
   initial begin
      i_reset = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      repeat (16) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      #1 chk({5'h00, o_group_a_mode} | {5'h00, o_group_b_mode}, 8'h01);
      chk(o_pa_oe | o_pb_oe | o_pc_oe, 8'h00);
      rdchk(8'h0c, 8'h00);
      wr(8'h10, 8'h77);
      rdchk(8'h10, 8'h00);
      foreach (rows[i]) begin
         wr(8'h00, 8'hff);
         wr(8'h04, 8'hff);
         wr(8'h0c, rows[i][47:40]);
         #1 chk({5'h00, o_group_a_mode}, rows[i][39:32]);
         chk({5'h00, o_group_b_mode}, rows[i][31:24]);
         chk(o_pa_oe, rows[i][23:16]);
         chk(o_pb_oe, rows[i][15:8]);
         chk(o_pc_oe, rows[i][7:0]);
         chk(o_pa | o_pb, 8'h00);
      end
      // set every pc bit with junk in the ignored field, then clear each
      wr(8'h0c, 8'h80);
      exp = 8'h00;
      for (int k = 0; k < 16; k++) begin
         wr(8'h0c, {4'h7, 3'(k), 1'(k < 8)});
         exp[k % 8] = (k < 8);
         #1 chk(o_pc, exp);
      end
      wr(8'h00, 8'ha5);
      #1 chk(o_pa, 8'ha5);
      wr(8'h0c, 8'h9b);
      i_pio_periph.send(8'h3c, 0);
      repeat (3) @(posedge i_sys_clk);
      rdchk(8'h04, 8'hc3);
      wr(8'h0c, 8'hb8);
      wr(8'h0c, 8'h09);
      i_pio_periph.send(8'h3c, 5);
      wait_pc(5, 1'b1);
      wait_pc(3, 1'b1);
      rdchk(8'h00, 8'h3c);
      chk(o_pc & 8'h28, 8'h00);
      // a repeated mode write must drop the enable set above
      wr(8'h0c, 8'hb8);
      i_pio_periph.send(8'h5a, 0);
      wait_pc(5, 1'b1);
      repeat (4) @(posedge i_sys_clk);
      #1 chk(o_pc & 8'h08, 8'h00);
      wr(8'h0c, 8'ha0);
      wr(8'h0c, 8'h0d);
      wr(8'h00, 8'h96);
      wait_pc(7, 1'b0);
      repeat (6) @(posedge i_sys_clk);
      #1 chk(o_pc & 8'h88, 8'h00);
      chk(o_pa, 8'h96);
      i_pio_periph.accept(3);
      wait_pc(7, 1'b1);
      wait_pc(3, 1'b1);
      wr(8'h00, 8'h69);
      wait_pc(3, 1'b0);
      wr(8'h0c, 8'h86);
      wr(8'h0c, 8'h05);
      i_pio_periph.send(8'he7, 2);
      wait_pc(1, 1'b1);
      wait_pc(0, 1'b1);
      rdchk(8'h04, 8'he7);
      chk(o_pc & 8'h03, 8'h00);
      // group b strobed output through the shared pc2 accept line
      wr(8'h0c, 8'h84);
      wr(8'h0c, 8'h05);
      wr(8'h04, 8'h3e);
      wait_pc(1, 1'b0);
      chk(o_pb, 8'h3e);
      i_pio_periph.accept(1);
      wait_pc(1, 1'b1);
      wait_pc(0, 1'b1);
      wr(8'h04, 8'hc1);
      wait_pc(0, 1'b0);
      wr(8'h0c, 8'hc0);
      wr(8'h00, 8'h81);
      wait_pc(7, 1'b0);
      chk(o_pa_oe, 8'h00);
      fork
         i_pio_periph.accept(0);
         begin
            for (n = 0; n < 12 && o_pa_oe !== 8'hff; n++) @(posedge i_sys_clk);
            chk(o_pa_oe, 8'hff);
            chk(o_pa, 8'h81);
            if (n == 12) print_verdict();
         end
      join
      i_pio_periph.send(8'h42, 0);
      wait_pc(5, 1'b1);
      rdchk(8'h00, 8'h42);
      // reset in mid-run must restore the all-input basic setup
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      #1 chk(o_pa_oe | o_pb_oe | o_pc_oe, 8'h00);
      chk(o_pa, 8'h00);
      chk({5'h00, o_group_a_mode} | {5'h00, o_group_b_mode}, 8'h01);
      rdchk(8'h0c, 8'h00);
      print_verdict();
   end
endmodule // pio_port_test
